// ===== hdl/drt_pkg.sv
// package: register map, field layout, keys, reset values and prescaler width of the refresh timer
package drt_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000; // control/status
  localparam logic [11:0] ADDR_INTERVAL = 12'h004; // interval counter
  localparam logic [11:0] ADDR_TIME_CONST = 12'h008; // time constant
  localparam logic [11:0] ADDR_TALLY = 12'h00C; // refresh tally counter
  localparam logic [11:0] ADDR_MEM_CTRL = 12'h010; // memory control (refresh enable, mode)
  // ----------------------------------------
  // control/status field positions
  // ----------------------------------------
  localparam int CS_CMF = 7; // compare match flag
  localparam int CS_COMPARE_MATCH_IRQ_ENABLE = 6; // compare match irq enable
  localparam int CS_CKS_HI = 5; // clock select msb
  localparam int CS_CKS_LO = 3; // clock select lsb
  localparam int CS_OVF = 2; // overflow flag
  localparam int CS_REFRESH_OVERFLOW_IRQ_ENABLE = 1; // overflow irq enable
  localparam int CS_OVERFLOW_LIMIT_SELECT = 0; // limit select
  // memory control field positions
  localparam int MC_REFRESH_ENABLE_BIT = 0; // refresh enable
  localparam int MC_CBR = 1; // cas-before-ras mode selected
  // ----------------------------------------
  // write keys and reset values
  // ----------------------------------------
  localparam logic [7:0] KEY_BYTE = 8'hA5; // upper byte key
  localparam logic [5:0] KEY_TALLY = 6'h29; // top six bits key for tally
  localparam logic [7:0] RST_BYTE = 8'h00; // power-on value of 8-bit regs
  localparam logic [9:0] RST_TALLY = 10'h000; // power-on value of tally
  localparam logic [10:0] LIMIT_1024 = 11'h400; // threshold with limit select 0
  localparam logic [10:0] LIMIT_512 = 11'h200; // threshold with limit select 1
  // prescaler: width of the free running divide counter
  localparam int PRESC_W = 12; // prescaler width, covers /4096
endpackage

// ===== hdl/drt_refresh_timer.sv
// refresh interval timer with keyed apb registers and refresh request output
// Summary of operation
// RULE_01: 8-bit interval counter ticks on prescaled clock
// RULE_02: match with constant sets flag, clears counter
// RULE_03: reset clears counter; a match also clears it and a write loads it
// RULE_04: reset clears time constant; otherwise retained
// RULE_05: refresh cycle per match if enabled and cbr
// RULE_06: 10-bit tally increments on every match
// RULE_07: tally above limit sets overflow, clears tally
// RULE_08: reset clears tally; otherwise retained
// RULE_09: writes only full 16-bit words accepted; memory control also takes low-byte writes
// RULE_10: software puts key in upper byte
// RULE_11: software puts 6-bit key atop tally writes
// RULE_12: 16-bit reads, unused upper bits zero
// RULE_13: limit select: 0 gives 1024, 1 gives 512
// RULE_14: clock select stops or divides 4..4096
// RULE_15: interrupt on enabled flags; write zero clears
// RULE_16: wrong key writes are ignored
`timescale 1ns/1ps
module drt_refresh_timer (
  input wire logic i_sys_clk, // system clock, 100 MHz
  input wire logic i_sys_rst, // synchronous power-on reset, active high
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic i_pwrite, // apb direction, high for write
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb byte strobes
  output logic o_pready, // apb ready
  output logic [31:0] o_prdata, // apb read data
  output logic o_pslverr, // apb error
  output logic o_refresh_req, // one-cycle refresh cycle request
  output logic o_irq // level interrupt
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] interval_reg; // interval counter
  logic [7:0] tconst_reg; // time constant
  logic [9:0] tally_reg; // refresh tally
  logic cmf_reg; // compare match flag
  logic compare_match_irq_enable_reg; // compare irq enable
  logic [2:0] cks_reg; // clock select
  logic ovf_reg; // overflow flag
  logic refresh_overflow_irq_enable_reg; // overflow irq enable
  logic overflow_limit_select_reg; // limit select
  logic refresh_enable_bit_reg; // refresh enable
  logic cbr_reg; // cas-before-ras mode
  localparam int PRESC_W_L = drt_pkg::PRESC_W; // prescaler width
  logic [PRESC_W_L-1:0] presc_reg; // free running prescaler
  logic [PRESC_W_L-1:0] presc_next; // prescaler next value
  // the /4096 tap needs exactly twelve bits; the tick masks below are that wide
  if (PRESC_W_L != 12) begin : g_presc_width
    $error("prescaler width must be 12");
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire bus_acc = i_psel && i_penable; // access phase
  wire full_word = i_pstrb[0] && i_pstrb[1]; // low 16 bits both written
  wire wr_ok = bus_acc && i_pwrite && full_word; // byte writes refused
  wire key_ok = i_pwdata[15:8] == drt_pkg::KEY_BYTE; // byte-reg key
  wire tkey_ok = i_pwdata[15:10] == drt_pkg::KEY_TALLY; // tally key
  wire hit_cs = i_paddr == drt_pkg::ADDR_CTRL_STATUS;
  wire hit_iv = i_paddr == drt_pkg::ADDR_INTERVAL;
  wire hit_tc = i_paddr == drt_pkg::ADDR_TIME_CONST;
  wire hit_ta = i_paddr == drt_pkg::ADDR_TALLY;
  wire hit_mc = i_paddr == drt_pkg::ADDR_MEM_CTRL;
  wire mapped = hit_cs || hit_iv || hit_tc || hit_ta || hit_mc;
  wire wr_cs = wr_ok && hit_cs && key_ok; // RULE_09 RULE_16
  wire wr_iv = wr_ok && hit_iv && key_ok; // RULE_16
  wire wr_tc = wr_ok && hit_tc && key_ok; // RULE_16
  wire wr_ta = wr_ok && hit_ta && tkey_ok; // RULE_16
  wire wr_mc = bus_acc && i_pwrite && i_pstrb[0] && hit_mc;

  // ----------------------------------------
  // prescaler tick
  // ----------------------------------------
  // divide ratio 2^n: tick when the low n bits of the free counter are all ones
  function automatic logic [11:0] mask_of(input logic [2:0] cks);
    unique case (cks)
      3'h1: mask_of = 12'h003;
      3'h2: mask_of = 12'h00F;
      3'h3: mask_of = 12'h03F;
      3'h4: mask_of = 12'h0FF;
      3'h5: mask_of = 12'h3FF;
      3'h6: mask_of = 12'h7FF;
      3'h7: mask_of = 12'hFFF;
      default: mask_of = 12'h000;
    endcase
  endfunction
  assign presc_next = presc_reg + 1'b1;
  wire [11:0] tick_mask = mask_of(cks_reg); // low bits that must all be set
  // a mask compare sees no false edge when the select changes mid-count
  wire tick = (cks_reg != 3'h0) && ((presc_reg & tick_mask) == tick_mask); // RULE_14 RULE_01

  // ----------------------------------------
  // compare and tally
  // ----------------------------------------
  wire match = tick && (interval_reg == tconst_reg); // RULE_02
  wire [10:0] tally_inc = {1'b0, tally_reg} + 11'h001; // RULE_06
  wire [10:0] limit = overflow_limit_select_reg ? drt_pkg::LIMIT_512 : drt_pkg::LIMIT_1024; // RULE_13
  // the 10-bit tally cannot hold 1024, so overflow is taken when the increment reaches the limit
  wire over = match && (tally_inc >= limit); // RULE_07
  // clear-by-zero writes; set wins over clear in the same cycle
  wire cmf_next = match || (cmf_reg && !(wr_cs && !i_pwdata[drt_pkg::CS_CMF])); // RULE_15
  wire ovf_next = over || (ovf_reg && !(wr_cs && !i_pwdata[drt_pkg::CS_OVF])); // RULE_15
  wire irq_next = (cmf_next && compare_match_irq_enable_reg) || (ovf_next && refresh_overflow_irq_enable_reg); // RULE_15

  // read mux; unused upper bits return zero
  wire [15:0] cs_view = {8'h00, cmf_reg, compare_match_irq_enable_reg, cks_reg, ovf_reg, refresh_overflow_irq_enable_reg, overflow_limit_select_reg};
  wire [15:0] rd_mux = hit_cs ? cs_view :
                       hit_iv ? {8'h00, interval_reg} :
                       hit_tc ? {8'h00, tconst_reg} :
                       hit_ta ? {6'h00, tally_reg} :
                       hit_mc ? {14'h0000, cbr_reg, refresh_enable_bit_reg} : 16'h0000; // RULE_12

  // ----------------------------------------
  // prescaler and counters
  // ----------------------------------------
  // only power-on reset exists here; the prescaler runs always
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_next;
    end
  end

  // interval counter: software write takes priority over count
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      interval_reg <= drt_pkg::RST_BYTE; // RULE_03
    end else if (wr_iv) begin
      interval_reg <= i_pwdata[7:0];
    end else if (match) begin
      interval_reg <= 8'h00; // RULE_02
    end else if (tick) begin
      interval_reg <= interval_reg + 8'h01; // RULE_01
    end
  end

  // time constant
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tconst_reg <= drt_pkg::RST_BYTE; // RULE_04
    end else if (wr_tc) begin
      tconst_reg <= i_pwdata[7:0];
    end
  end

  // tally: hardware overflow clear beats a coincident write
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tally_reg <= drt_pkg::RST_TALLY; // RULE_08
    end else if (over) begin
      tally_reg <= drt_pkg::RST_TALLY; // RULE_07
    end else if (match) begin
      tally_reg <= tally_inc[9:0]; // RULE_06
    end else if (wr_ta) begin
      tally_reg <= i_pwdata[9:0];
    end
  end

  // ----------------------------------------
  // control/status and memory control
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cmf_reg <= 1'b0;
      ovf_reg <= 1'b0;
      compare_match_irq_enable_reg <= 1'b0;
      cks_reg <= 3'h0;
      refresh_overflow_irq_enable_reg <= 1'b0;
      overflow_limit_select_reg <= 1'b0;
    end else begin
      cmf_reg <= cmf_next;
      ovf_reg <= ovf_next;
      if (wr_cs) begin
        compare_match_irq_enable_reg <= i_pwdata[drt_pkg::CS_COMPARE_MATCH_IRQ_ENABLE];
        cks_reg <= i_pwdata[drt_pkg::CS_CKS_HI:drt_pkg::CS_CKS_LO];
        refresh_overflow_irq_enable_reg <= i_pwdata[drt_pkg::CS_REFRESH_OVERFLOW_IRQ_ENABLE];
        overflow_limit_select_reg <= i_pwdata[drt_pkg::CS_OVERFLOW_LIMIT_SELECT];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      refresh_enable_bit_reg <= 1'b0;
      cbr_reg <= 1'b0;
    end else if (wr_mc) begin
      refresh_enable_bit_reg <= i_pwdata[drt_pkg::MC_REFRESH_ENABLE_BIT];
      cbr_reg <= i_pwdata[drt_pkg::MC_CBR];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero-wait slave: ready in every access phase
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_refresh_req <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_prdata <= {16'h0000, rd_mux};
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_refresh_req <= match && refresh_enable_bit_reg && cbr_reg; // RULE_05
      o_irq <= irq_next;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_match_clears;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (match && !wr_iv) |=> (interval_reg == 8'h00) && cmf_reg;
  endproperty
  a_match_clears: assert property (p_match_clears) else $error("match did not clear counter"); // RULE_02
  property p_tick_inc;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (tick && !match && !wr_iv) |=> interval_reg == $past(interval_reg) + 8'h01;
  endproperty
  a_tick_inc: assert property (p_tick_inc) else $error("counter did not advance"); // RULE_01
  property p_stopped;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (cks_reg == 3'h0) |-> !tick;
  endproperty
  a_stopped: assert property (p_stopped) else $error("tick with clock stopped"); // RULE_14
  property p_refresh;
    @(posedge i_sys_clk) disable iff (i_sys_rst) match |=> o_refresh_req == ($past(refresh_enable_bit_reg) && $past(cbr_reg));
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh request wrong"); // RULE_05
  property p_tally;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (match && !over) |=> tally_reg == $past(tally_reg) + 10'h001;
  endproperty
  a_tally: assert property (p_tally) else $error("tally did not increment"); // RULE_06
  property p_over;
    @(posedge i_sys_clk) disable iff (i_sys_rst) over |=> ovf_reg && (tally_reg == 10'h000);
  endproperty
  a_over: assert property (p_over) else $error("overflow not handled"); // RULE_07
  property p_badkey;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (bus_acc && i_pwrite && hit_tc && !key_ok) |=> $stable(tconst_reg);
  endproperty
  a_badkey: assert property (p_badkey) else $error("bad key write changed register"); // RULE_16
  property p_irq;
    @(posedge i_sys_clk) disable iff (i_sys_rst) ##1 o_irq == $past(irq_next);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong"); // RULE_15
  property p_upper_zero;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (i_psel && !i_penable) |=> o_prdata[31:10] == 22'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved bits nonzero"); // RULE_12
  // flags: set beats a coincident clear, a lone clear takes
  sequence s_cmf_clear;
    wr_cs && !i_pwdata[drt_pkg::CS_CMF] && !match;
  endsequence
  property p_set_wins;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (match && wr_cs && !i_pwdata[drt_pkg::CS_CMF]) |=> cmf_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a coincident match"); // RULE_15
  property p_cmf_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst) s_cmf_clear |=> !cmf_reg;
  endproperty
  a_cmf_clear: assert property (p_cmf_clear) else $error("zero write did not clear flag"); // RULE_15
  // guarded writes: byte strobes to the time constant and bad tally keys leave contents alone
  property p_byte_write;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (bus_acc && i_pwrite && !full_word && hit_tc) |=> $stable(tconst_reg);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write changed register"); // RULE_09
  property p_tally_badkey;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (bus_acc && i_pwrite && hit_ta && !tkey_ok && !match) |=> $stable(tally_reg);
  endproperty
  a_tally_badkey: assert property (p_tally_badkey) else $error("bad key changed tally"); // RULE_16
  property p_tc_keep;
    @(posedge i_sys_clk) disable iff (i_sys_rst) !wr_tc |=> $stable(tconst_reg);
  endproperty
  a_tc_keep: assert property (p_tc_keep) else $error("time constant changed unwritten"); // RULE_04
  // overflow thresholds checked on the tally against one below each limit (3FF, 1FF), not the adder
  property p_limit_lo;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (match && !overflow_limit_select_reg) |-> over == (tally_reg == 10'h3FF);
  endproperty
  a_limit_lo: assert property (p_limit_lo) else $error("overflow wrong at limit 1024"); // RULE_13
  property p_limit_hi;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (match && overflow_limit_select_reg) |-> over == (tally_reg >= 10'h1FF);
  endproperty
  a_limit_hi: assert property (p_limit_hi) else $error("overflow wrong at limit 512"); // RULE_13
  // refresh request: one pulse, one cycle after the match
  sequence s_refresh_due;
    match && refresh_enable_bit_reg && cbr_reg;
  endsequence
  property p_refresh_pulse;
    @(posedge i_sys_clk) disable iff (i_sys_rst) s_refresh_due |=> o_refresh_req ##1 !o_refresh_req;
  endproperty
  a_refresh_pulse: assert property (p_refresh_pulse) else $error("refresh pulse shape wrong"); // RULE_05
endmodule

// ===== sim/test_dram_refresh_timer.sv
// self-checking bench for the refresh timer: keyed apb registers, match, tally, irq
`timescale 1ns/1ps
module test_dram_refresh_timer;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [3:0] i_pstrb = 4'h0;
  logic o_pready;
  logic [31:0] o_prdata;
  logic o_pslverr;
  logic o_refresh_req;
  logic o_irq;
  int errors = 0;
  int total_checks = 0;
  int refresh_cnt = 0; // refresh pulses seen since start
  logic [31:0] rd; // data of the last read
  logic [31:0] rd2; // second sample for stability checks
  logic er; // error flag of the last transfer
  typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} drt_row_t;
  drt_row_t rows[7] = '{
    '{12'h008, 32'h0000_A53C, 4'hF, 32'h0000_003C}, // keyed write lands
    '{12'h008, 32'h0000_5A11, 4'hF, 32'h0000_003C}, // wrong key ignored
    '{12'h008, 32'h0000_A522, 4'h1, 32'h0000_003C}, // byte write ignored
    '{12'h00C, 32'h0000_A6AB, 4'hF, 32'h0000_02AB}, // tally key 101001 in 15:10
    '{12'h00C, 32'h0000_0155, 4'hF, 32'h0000_02AB}, // tally without key ignored
    '{12'h004, 32'h0000_A510, 4'hF, 32'h0000_0010}, // interval written, clock stopped
    '{12'h000, 32'h0000_A585, 4'hF, 32'h0000_0001}  // writing one to flags keeps zero
  };

  drt_refresh_timer DUT (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .o_pready(o_pready),
    .o_prdata(o_prdata),
    .o_pslverr(o_pslverr),
    .o_refresh_req(o_refresh_req),
    .o_irq(o_irq)
  );

  // ----------------------------------------
  // clock, pulse monitor, watchdog
  // ----------------------------------------
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // sampled mid-cycle so the registered pulse is settled
  always @(negedge i_sys_clk) begin
    if (o_refresh_req === 1'b1) refresh_cnt++;
  end
  // whole run is a few hundred cycles; this is generous
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // apb transfer; pready is sampled at the rising edge, the request held until then
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    // no cycle count is assumed; only the watchdog ends a wait for ready
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    wait_clk(16);
    i_sys_rst <= 1'b0;
    wait_clk(1);
    // reset values with zero upper bits
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, 4'hF);
      chk(rd, 32'h0000_0000);
    end
    // table of writes and read-backs
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      apb(1'b0, rows[i].a, 32'h0, 4'hF);
      chk(rd, rows[i].e);
    end
    apb(1'b0, 12'h020, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    // matches at constant 3, tally preset to the 512 limit, interrupts masked
    apb(1'b1, 12'h010, 32'h0000_0003, 4'h1);
    apb(1'b1, 12'h008, 32'h0000_A503, 4'hF);
    apb(1'b1, 12'h004, 32'h0000_A500, 4'hF);
    apb(1'b1, 12'h00C, 32'h0000_A600, 4'hF);
    apb(1'b1, 12'h000, 32'h0000_A509, 4'hF);
    wait_clk(60);
    chk(o_irq, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_A585, 4'hF);
    wait_clk(2);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk(rd, 32'h0000_0085);
    chk(refresh_cnt >= 2, 1'b1);
    apb(1'b0, 12'h00C, 32'h0, 4'hF);
    chk(rd, 32'(refresh_cnt - 1));
    apb(1'b0, 12'h004, 32'h0, 4'hF);
    rd2 = rd;
    wait_clk(20);
    apb(1'b0, 12'h004, 32'h0, 4'hF);
    chk(rd, rd2);
    chk(rd < 32'h4, 1'b1);
    // unmask, clear one flag at a time
    apb(1'b1, 12'h000, 32'h0000_A5C5, 4'hF);
    wait_clk(2);
    chk(o_irq, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_A545, 4'hF);
    wait_clk(2);
    chk(o_irq, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_A547, 4'hF);
    wait_clk(2);
    chk(o_irq, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_A543, 4'hF);
    wait_clk(2);
    chk(o_irq, 1'b0);
    // refresh disabled: matches go on without refresh cycles
    apb(1'b1, 12'h010, 32'h0000_0002, 4'h1);
    rd2 = 32'(refresh_cnt);
    apb(1'b1, 12'h000, 32'h0000_A508, 4'hF);
    wait_clk(60);
    chk(32'(refresh_cnt), rd2);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk(rd[7], 1'b1);
    // limit 1024: stop, preset tally to 1023, one match must overflow
    apb(1'b1, 12'h000, 32'h0000_A500, 4'hF);
    apb(1'b1, 12'h00C, 32'h0000_A7FF, 4'hF);
    apb(1'b1, 12'h004, 32'h0000_A500, 4'hF);
    apb(1'b1, 12'h000, 32'h0000_A508, 4'hF);
    wait_clk(20);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk(32'(rd[2]), 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0, 4'hF);
    chk(32'(rd < 32'h2), 32'h0000_0001);
    // second reset in mid-run clears the constant
    i_sys_rst <= 1'b1;
    wait_clk(2);
    i_sys_rst <= 1'b0;
    wait_clk(1);
    apb(1'b0, 12'h008, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
